// ==== rtl/mmiosu_pkg.sv ====
// Constants, register map and types of the molding machine I/O signal unit.
// Assumes a 10 MHz system clock and a 32-bit APB register bus.
package mmiosu_pkg;

    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int NUM_IN  = 4;
    localparam int NUM_CH  = 8;
    localparam int NUM_OUT = 8;

    // Input order on the synchroniser
    localparam int IN_START = 0;
    localparam int IN_ACLR  = 1;
    localparam int IN_CTRL  = 2;
    localparam int IN_CCLR  = 3;

    // Output function order
    localparam int OUT_ALARM  = 0;
    localparam int OUT_GOOD   = 1;
    localparam int OUT_SHOT   = 2;
    localparam int OUT_PROD   = 3;
    localparam int OUT_CONT   = 4;
    localparam int OUT_AEN    = 5;
    localparam int OUT_SWITCH = 6;
    localparam int OUT_MOLD   = 7;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_OUTCFG = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_TARGET = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CLIMIT = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_GOOD   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CONSEC = 8'h18;

    // Control register fields
    localparam int CTRL_MON_EN   = 0;
    localparam int CTRL_XCLR_EN  = 1;
    localparam int CTRL_TRIG_LSB = 2;
    localparam int CTRL_EDGE_LSB = 4;
    localparam int CTRL_FUNC_LSB = 8;

    // Output configuration fields
    localparam int OCF_SENSE_LSB = 0;
    localparam int OCF_ATRIG_LSB = 8;
    localparam int OCF_GTRIG_LSB = 10;
    localparam int OCF_SW_ANY    = 12;
    localparam int OCF_MO_ANY    = 13;
    localparam int OCF_SWSEL_LSB = 16;
    localparam int OCF_MOSEL_LSB = 24;

    // Writable bits and reset values
    localparam logic [DATA_W-1:0] CTRL_MASK   = 32'h0000_03ff;
    localparam logic [DATA_W-1:0] OUTCFG_MASK = 32'hffff_3fff;
    localparam logic [DATA_W-1:0] TARGET_MASK = 32'h0000_ffff;
    localparam logic [DATA_W-1:0] CLIMIT_MASK = 32'h0000_00ff;
    localparam logic [DATA_W-1:0] CTRL_RST    = 32'h0000_0004;
    localparam logic [DATA_W-1:0] OUTCFG_RST  = 32'h0000_0500;
    localparam logic [DATA_W-1:0] TARGET_RST  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CLIMIT_RST  = 32'h0000_0000;

    // Shot end pulse width
    localparam int CLK_NS         = 100;
    localparam int SHOT_PULSE_NS  = 10000;
    localparam int SHOT_PULSE_CYC = (SHOT_PULSE_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        MMIOSU_FN_TRIG,
        MMIOSU_FN_ALARM,
        MMIOSU_FN_SAVE,
        MMIOSU_FN_NONE
    } mmiosu_func_t;

endpackage

// ==== rtl/mmiosu_edge_if.sv ====
// Carries settled levels and edge pulses of the external inputs.
// Assumes producer and consumer share one clock.
`timescale 1ns/1ps
`default_nettype none
interface mmiosu_edge_if;
    logic [mmiosu_pkg::NUM_IN-1:0] lvl;
    logic [mmiosu_pkg::NUM_IN-1:0] rise;
    logic [mmiosu_pkg::NUM_IN-1:0] fall;
    modport src (output lvl, rise, fall);
    modport dst (input lvl, rise, fall);
endinterface
`default_nettype wire

// ==== rtl/mmiosu_edge_sync.sv ====
// Three-stage synchroniser and edge detector for the external inputs.
// Assumes raw pins are asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module mmiosu_edge_sync (
    input  wire logic                          ref_clk,
    input  wire logic                          rst_b,
    input  wire logic [mmiosu_pkg::NUM_IN-1:0] raw_in,
    mmiosu_edge_if.src                         edges
);
    import mmiosu_pkg::*;

    logic [NUM_IN-1:0] s1_q, s2_q, s3_q, lvl_q, prv_q;
    logic [NUM_IN-1:0] lvl_d;

    // Level moves only when stages two and three agree
    always_comb begin
        lvl_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q); // [RULE19]
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
            prv_q <= '0;
        end else begin
            s1_q  <= raw_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
            prv_q <= lvl_q;
        end
    end

    assign edges.lvl  = lvl_q;
    assign edges.rise = lvl_q & ~prv_q; // [RULE19]
    assign edges.fall = ~lvl_q & prv_q; // [RULE19]

endmodule
`default_nettype wire

// ==== rtl/mmiosu_top.sv ====
// Discrete I/O signal unit facing an injection molding machine.
// Assumes shot results and channel threshold flags come from logic on ref_clk.
// Notes on behaviour
// [RULE1] Start measurement on the chosen rising or falling edge of start input.
// [RULE2] Start input carries a trigger number from one to three; the code also passes zero from the control register.
// [RULE3] Alarm clear edge clears the alarm only when external clearing is on.
// [RULE4] Alarm clear input has its own edge selection.
// [RULE5] Control input edge disables the configured function.
// [RULE6] Control function picks one of trigger, alarm or save inhibit.
// [RULE7] Continuous alarm clear edge clears the continuous alarm.
// [RULE8] Each output is normally open or normally closed.
// [RULE9] Alarm output asserts on an alarm for its trigger number.
// [RULE10] Shot end output pulses on each completed shot.
// [RULE11] Good shots are counted; product complete asserts at target.
// [RULE12] Continuous error asserts when consecutive alarms reach the limit.
// [RULE13] Alarm enable output is on while monitoring is enabled.
// [RULE14] All-channels switchover needs every selected channel above threshold.
// [RULE15] Any-channel switchover needs one selected channel above threshold.
// [RULE16] All-channels mold open needs every selected channel below threshold.
// [RULE17] Any-channel mold open needs one selected channel below threshold.
// [RULE18] Good-shot output asserts on a clean shot of its trigger number.
// [RULE19] Inputs are synchronised; edges compare current and previous level.
// [RULE20] Consecutive count clears on a clean shot and on continuous clear.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module mmiosu_top (
    input  wire logic                          ref_clk,
    input  wire logic                          rst_b,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [mmiosu_pkg::ADDR_W-1:0] paddr,
    input  wire logic [mmiosu_pkg::DATA_W-1:0] pwdata,
    output logic      [mmiosu_pkg::DATA_W-1:0] prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          start_trig_in,
    input  wire logic                          alarm_clr_in,
    input  wire logic                          control_in,
    input  wire logic                          cont_clr_in,
    input  wire logic                          shot_done,
    input  wire logic                          shot_alarm,
    input  wire logic [1:0]                    shot_trig,
    input  wire logic [mmiosu_pkg::NUM_CH-1:0] ch_above,
    input  wire logic [mmiosu_pkg::NUM_CH-1:0] ch_below,
    output logic                               meas_start,
    output logic      [1:0]                    meas_trig_num,
    output logic                               save_inhibit,
    output logic                               alarm_out,
    output logic                               good_shot_out,
    output logic                               shot_end_out,
    output logic                               product_done_out,
    output logic                               cont_error_out,
    output logic                               alarm_enable_out,
    output logic                               fill_to_pack_switchover_out,
    output logic                               mold_open_out
);
    import mmiosu_pkg::*;

    mmiosu_edge_if edges ();

    mmiosu_edge_sync u_sync (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .raw_in  ({cont_clr_in, control_in, alarm_clr_in, start_trig_in}),
        .edges   (edges)
    );

    // Register bus and configuration state
    logic [DATA_W-1:0] ctrl_q, ctrl_d, ocfg_q, ocfg_d;
    logic [DATA_W-1:0] tgt_q, tgt_d, clim_q, clim_d;
    logic [DATA_W-1:0] prdata_q, prdata_d, rmux;
    logic              ack_q, ack_d;
    logic              access, addr_ok, wr_en, good_clr;

    // Event state
    logic               meas_q, meas_d;
    logic               inh_q, inh_d;
    logic               alm_q, alm_d;
    logic               gsh_q, gsh_d;
    logic               cerr_q, cerr_d;
    logic [7:0]         pcnt_q, pcnt_d;
    logic [15:0]        good_q, good_d;
    logic [7:0]         cons_q, cons_d;
    logic [NUM_OUT-1:0] port_q, port_d;

    // Decoded configuration
    logic               mon_en, xclr_en;
    logic [NUM_IN-1:0]  fall_sel, hit, opp;
    mmiosu_func_t       func;
    logic               trig_inh, alarm_inh;
    logic [1:0]         atrig, gtrig;
    logic [NUM_OUT-1:0] sense, fn;
    logic [NUM_CH-1:0]  sw_sel, mo_sel;
    logic               alarmed, clean, prod_done, cons_hit;
    logic [7:0]         cons_inc;

    assign mon_en    = ctrl_q[CTRL_MON_EN];
    assign xclr_en   = ctrl_q[CTRL_XCLR_EN];
    assign fall_sel  = ctrl_q[CTRL_EDGE_LSB +: NUM_IN];
    assign func      = mmiosu_func_t'(ctrl_q[CTRL_FUNC_LSB +: 2]);
    assign atrig     = ocfg_q[OCF_ATRIG_LSB +: 2];
    assign gtrig     = ocfg_q[OCF_GTRIG_LSB +: 2];
    assign sense     = ocfg_q[OCF_SENSE_LSB +: NUM_OUT];
    assign sw_sel    = ocfg_q[OCF_SWSEL_LSB +: NUM_CH];
    assign mo_sel    = ocfg_q[OCF_MOSEL_LSB +: NUM_CH];

    // Each input picks its own edge; the opposite edge ends a control inhibit
    assign hit = (edges.fall & fall_sel) | (edges.rise & ~fall_sel); // [RULE1] [RULE4]
    assign opp = (edges.rise & fall_sel) | (edges.fall & ~fall_sel);

    assign trig_inh  = inh_q && (func == MMIOSU_FN_TRIG);  // [RULE6]
    assign alarm_inh = inh_q && (func == MMIOSU_FN_ALARM); // [RULE6]

    // APB: one wait state so read data comes from a flop
    assign access  = psel && penable;
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= OFS_CONSEC);
    assign pready  = access && ack_q;
    assign pslverr = pready && !addr_ok;
    assign wr_en   = pready && pwrite && addr_ok;
    assign prdata  = prdata_q;
    assign good_clr = wr_en && (paddr == OFS_GOOD);

    always_comb begin
        case (paddr)
            OFS_CTRL:   rmux = ctrl_q;
            OFS_OUTCFG: rmux = ocfg_q;
            OFS_TARGET: rmux = tgt_q;
            OFS_CLIMIT: rmux = clim_q;
            OFS_STATUS: rmux = {20'h0_0000, meas_trig_num, save_inhibit, alarm_inh, trig_inh,
                                prod_done, cerr_q, alm_q, edges.lvl};
            OFS_GOOD:   rmux = {16'h0000, good_q};
            OFS_CONSEC: rmux = {24'h00_0000, cons_q};
            default:    rmux = '0;
        endcase
    end

    always_comb begin
        ack_d    = access && !ack_q;
        prdata_d = (access && !ack_q && !pwrite) ? rmux : prdata_q;
        ctrl_d   = ctrl_q;
        ocfg_d   = ocfg_q;
        tgt_d    = tgt_q;
        clim_d   = clim_q;
        if (wr_en) begin
            case (paddr)
                OFS_CTRL:   ctrl_d = pwdata & CTRL_MASK;
                OFS_OUTCFG: ocfg_d = pwdata & OUTCFG_MASK;
                OFS_TARGET: tgt_d  = pwdata & TARGET_MASK;
                OFS_CLIMIT: clim_d = pwdata & CLIMIT_MASK;
                default:    ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_q    <= 1'b0;
            prdata_q <= '0;
            ctrl_q   <= CTRL_RST;
            ocfg_q   <= OUTCFG_RST;
            tgt_q    <= TARGET_RST;
            clim_q   <= CLIMIT_RST;
        end else begin
            ack_q    <= ack_d;
            prdata_q <= prdata_d;
            ctrl_q   <= ctrl_d;
            ocfg_q   <= ocfg_d;
            tgt_q    <= tgt_d;
            clim_q   <= clim_d;
        end
    end

    // Shot evaluation; alarm zone results arrive from outside
    assign alarmed   = shot_done && shot_alarm && mon_en && !alarm_inh;
    assign clean     = shot_done && !shot_alarm && mon_en && !alarm_inh;
    assign prod_done = (tgt_q[15:0] != 16'h0000) && (good_q >= tgt_q[15:0]);
    assign cons_inc  = (cons_q == 8'hff) ? cons_q : cons_q + 8'h01;
    assign cons_hit  = (clim_q[7:0] != 8'h00) && (cons_inc >= clim_q[7:0]);

    always_comb begin
        meas_d = hit[IN_START] && !trig_inh; // [RULE1] [RULE5]
        // Inhibit holds from the selected edge until the opposite one
        inh_d = hit[IN_CTRL] ? 1'b1 : (opp[IN_CTRL] ? 1'b0 : inh_q); // [RULE5]
        // A new alarm in the clearing cycle wins
        alm_d = alm_q;
        if (xclr_en && hit[IN_ACLR]) begin
            alm_d = 1'b0; // [RULE3]
        end
        if (alarmed && (shot_trig == atrig)) begin
            alm_d = 1'b1; // [RULE9]
        end
        gsh_d = gsh_q;
        if (shot_done && (shot_trig == gtrig)) begin
            gsh_d = clean; // [RULE18]
        end
        // Shot end pulse stretched so a slow machine input can see it
        if (shot_done) begin
            pcnt_d = 8'(SHOT_PULSE_CYC); // [RULE10]
        end else if (pcnt_q != 8'h00) begin
            pcnt_d = pcnt_q - 8'h01;
        end else begin
            pcnt_d = pcnt_q;
        end
        // Good count stops at a nonzero target; a shot in the clearing cycle counts as the first after the clear unless the count had reached the target
        good_d = good_clr ? 16'h0000 : good_q;
        if (clean && !prod_done) begin
            good_d = good_clr ? 16'h0001 : good_q + 16'h0001; // [RULE11]
        end
        cons_d = cons_q;
        cerr_d = cerr_q;
        if (hit[IN_CCLR]) begin
            cons_d = 8'h00; // [RULE20]
            cerr_d = 1'b0;  // [RULE7]
        end
        if (clean) begin
            cons_d = 8'h00; // [RULE20]
        end else if (alarmed) begin
            cons_d = hit[IN_CCLR] ? 8'h01 : cons_inc;
            if (hit[IN_CCLR] ? (clim_q[7:0] == 8'h01) : cons_hit) begin
                cerr_d = 1'b1; // [RULE12]
            end
        end
    end

    // Output functions before sense
    always_comb begin
        fn             = '0;
        fn[OUT_ALARM]  = alm_q;
        fn[OUT_GOOD]   = gsh_q;
        fn[OUT_SHOT]   = (pcnt_q != 8'h00);
        fn[OUT_PROD]   = prod_done;
        fn[OUT_CONT]   = cerr_q;
        fn[OUT_AEN]    = mon_en; // [RULE13]
        if (ocfg_q[OCF_SW_ANY]) begin
            fn[OUT_SWITCH] = |(ch_above & sw_sel); // [RULE15]
        end else begin
            fn[OUT_SWITCH] = (|sw_sel) && (&(ch_above | ~sw_sel)); // [RULE14]
        end
        if (ocfg_q[OCF_MO_ANY]) begin
            fn[OUT_MOLD] = |(ch_below & mo_sel); // [RULE17]
        end else begin
            fn[OUT_MOLD] = (|mo_sel) && (&(ch_below | ~mo_sel)); // [RULE16]
        end
        port_d = fn ^ sense; // [RULE8]
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meas_q <= 1'b0;
            inh_q  <= 1'b0;
            alm_q  <= 1'b0;
            gsh_q  <= 1'b0;
            cerr_q <= 1'b0;
            pcnt_q <= 8'h00;
            good_q <= 16'h0000;
            cons_q <= 8'h00;
            port_q <= '0;
        end else begin
            meas_q <= meas_d;
            inh_q  <= inh_d;
            alm_q  <= alm_d;
            gsh_q  <= gsh_d;
            cerr_q <= cerr_d;
            pcnt_q <= pcnt_d;
            good_q <= good_d;
            cons_q <= cons_d;
            port_q <= port_d;
        end
    end

    assign meas_start    = meas_q;
    assign meas_trig_num = ctrl_q[CTRL_TRIG_LSB +: 2]; // [RULE2]
    assign save_inhibit  = inh_q && (func == MMIOSU_FN_SAVE); // [RULE5]

    assign alarm_out                   = port_q[OUT_ALARM];
    assign good_shot_out               = port_q[OUT_GOOD];
    assign shot_end_out                = port_q[OUT_SHOT];
    assign product_done_out            = port_q[OUT_PROD];
    assign cont_error_out              = port_q[OUT_CONT];
    assign alarm_enable_out            = port_q[OUT_AEN];
    assign fill_to_pack_switchover_out = port_q[OUT_SWITCH];
    assign mold_open_out               = port_q[OUT_MOLD];

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    property p_start;
        hit[IN_START] && !trig_inh |=> meas_start;
    endproperty
    a_start: assert property (p_start) else $error("start edge did not start"); // [RULE1]

    property p_trig_inh;
        inh_q && func == MMIOSU_FN_TRIG |=> !meas_start;
    endproperty
    a_trig_inh: assert property (p_trig_inh) else $error("start while inhibited"); // [RULE5]

    property p_aclr;
        alm_q && xclr_en && hit[IN_ACLR] && !alarmed |=> !alm_q;
    endproperty
    a_aclr: assert property (p_aclr) else $error("alarm not cleared"); // [RULE3]

    property p_aclr_off;
        alm_q && !xclr_en |=> alm_q;
    endproperty
    a_aclr_off: assert property (p_aclr_off) else $error("alarm cleared while disabled"); // [RULE3]

    property p_sense;
        1'b1 |=> alarm_out == ($past(alm_q) ^ $past(sense[OUT_ALARM]));
    endproperty
    a_sense: assert property (p_sense) else $error("alarm output sense wrong"); // [RULE8]

    property p_alarm;
        alarmed && shot_trig == atrig |-> ##2 (alarm_out != $past(sense[OUT_ALARM]));
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm output missing"); // [RULE9]

    property p_shot_end;
        shot_done |=> (pcnt_q != 8'h00) ##1 (shot_end_out != $past(sense[OUT_SHOT]));
    endproperty
    a_shot_end: assert property (p_shot_end) else $error("shot end pulse missing"); // [RULE10]

    property p_product;
        tgt_q[15:0] != 16'h0000 && good_q == tgt_q[15:0]
            |=> product_done_out != $past(sense[OUT_PROD]);
    endproperty
    a_product: assert property (p_product) else $error("product complete missing"); // [RULE11]

    property p_cont;
        alarmed && !hit[IN_CCLR] && cons_hit |=> cerr_q;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous error missing"); // [RULE12]

    property p_cons_rst;
        clean |=> cons_q == 8'h00;
    endproperty
    a_cons_rst: assert property (p_cons_rst) else $error("consecutive count kept"); // [RULE20]

    property p_sw_any;
        ocfg_q[OCF_SW_ANY] && |(ch_above & sw_sel)
            |=> fill_to_pack_switchover_out != $past(sense[OUT_SWITCH]);
    endproperty
    a_sw_any: assert property (p_sw_any) else $error("any switchover missing"); // [RULE15]

    property p_mo_all;
        !ocfg_q[OCF_MO_ANY] && |(mo_sel & ~ch_below)
            |=> mold_open_out == $past(sense[OUT_MOLD]);
    endproperty
    a_mo_all: assert property (p_mo_all) else $error("mold open too early"); // [RULE16]

    c_start: cover property (meas_start);
    c_cont:  cover property ($rose(cerr_q));
    c_prod:  cover property ($rose(prod_done));
    c_clear: cover property ($fell(alm_q));

endmodule
`default_nettype wire

// ==== dv/mmiosu_machine.sv ====
// Machine side model: input pins, shot results, channel flags.
// Assumes tasks are called by the bench from one process.
`timescale 1ns/1ps
`default_nettype none
module mmiosu_machine (
    input  wire logic       ref_clk,
    output logic      [3:0] pins,
    output logic            shot_done,
    output logic            shot_alarm,
    output logic      [1:0] shot_trig,
    output logic      [7:0] ch_above,
    output logic      [7:0] ch_below
);
    initial begin
        pins = 4'h0;
        shot_done = 1'b0;
        shot_alarm = 1'b0;
        shot_trig = 2'h0;
        ch_above = 8'h00;
        ch_below = 8'h00;
    end
    task automatic set_pin(input int i, input logic v);
        @(posedge ref_clk);
        pins[i] <= v;
        repeat (4) @(posedge ref_clk); // Held past the synchroniser
    endtask
    task automatic shot(input logic al, input logic [1:0] tr);
        @(posedge ref_clk);
        shot_done <= 1'b1;
        shot_alarm <= al;
        shot_trig <= tr;
        @(posedge ref_clk);
        shot_done <= 1'b0;
        // Result lines carry junk outside the strobe, as a real machine may
        shot_alarm <= ~al;
        shot_trig <= ~tr;
    endtask
    task automatic chans(input logic [7:0] a, input logic [7:0] b);
        @(posedge ref_clk);
        ch_above <= a;
        ch_below <= b;
    endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the molding machine I/O signal unit.
// Assumes the machine model drives all pin and shot inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mmiosu_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, sd, sa, ms, sv;
    logic [1:0] st, mt;
    logic [3:0] pins;
    logic [7:0] cha, chb;
    wire [7:0] o;
    int n_errors = 0, samples_checked = 0, n_meas = 0;
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (ms === 1'b1) n_meas++;
    mmiosu_machine mach (.ref_clk(ref_clk), .pins(pins), .shot_done(sd), .shot_alarm(sa),
        .shot_trig(st), .ch_above(cha), .ch_below(chb));
    mmiosu_top uut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .start_trig_in(pins[IN_START]), .alarm_clr_in(pins[IN_ACLR]),
        .control_in(pins[IN_CTRL]), .cont_clr_in(pins[IN_CCLR]), .shot_done(sd),
        .shot_alarm(sa), .shot_trig(st), .ch_above(cha), .ch_below(chb), .meas_start(ms),
        .meas_trig_num(mt), .save_inhibit(sv), .alarm_out(o[0]), .good_shot_out(o[1]),
        .shot_end_out(o[2]), .product_done_out(o[3]), .cont_error_out(o[4]),
        .alarm_enable_out(o[5]), .fill_to_pack_switchover_out(o[6]), .mold_open_out(o[7]));
    task automatic test_done();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Request stands until pready is seen at a rising edge; only the watchdog ends a hang
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        cyc(1);
    endtask
    task automatic pulse_pin(input int i);
        mach.set_pin(i, 1'b1);
        mach.set_pin(i, 1'b0);
        cyc(2);
    endtask
    task automatic t_regs();
        apb(0, OFS_CTRL, 0);
        chk(rd, CTRL_RST);
        apb(0, OFS_OUTCFG, 0);
        chk(rd, OUTCFG_RST);
        chk(mt, 2'h1);
        apb(1, OFS_CTRL, 32'h0000_030d);
        chk(mt, 2'h3);
        apb(0, 8'h1c, 0);
        chk({err, rd}, {1'b1, 32'h0});
    endtask
    task automatic t_start();
        int n0;
        apb(1, OFS_CTRL, 32'h0000_0305);
        n0 = n_meas;
        pulse_pin(IN_START);
        chk(n_meas - n0, 1);
        apb(1, OFS_CTRL, 32'h0000_0315);
        mach.set_pin(IN_START, 1'b1);
        cyc(2);
        chk(n_meas - n0, 1);
        mach.set_pin(IN_START, 1'b0);
        cyc(2);
        chk(n_meas - n0, 2);
    endtask
    task automatic t_ctrl();
        int n0;
        apb(1, OFS_CTRL, 32'h0000_0005);
        n0 = n_meas;
        mach.set_pin(IN_CTRL, 1'b1);
        pulse_pin(IN_START);
        chk(n_meas - n0, 0);
        mach.set_pin(IN_CTRL, 1'b0);
        pulse_pin(IN_START);
        chk(n_meas - n0, 1);
        apb(1, OFS_CTRL, 32'h0000_0205);
        mach.set_pin(IN_CTRL, 1'b1);
        cyc(2);
        chk(sv, 1'b1);
        mach.set_pin(IN_CTRL, 1'b0);
        cyc(2);
        chk(sv, 1'b0);
    endtask
    task automatic t_alarm();
        apb(1, OFS_CTRL, 32'h0000_0305);
        mach.shot(1'b1, 2'h2);
        cyc(3);
        chk(o[0], 1'b0);
        mach.shot(1'b1, 2'h1);
        cyc(3);
        chk(o[2:0], 3'b101);
        pulse_pin(IN_ACLR);
        chk(o[0], 1'b1);
        apb(1, OFS_CTRL, 32'h0000_0307);
        pulse_pin(IN_ACLR);
        chk(o[0], 1'b0);
        // Clear moved to the falling edge: the rise alone must leave the alarm set
        mach.shot(1'b1, 2'h1);
        apb(1, OFS_CTRL, 32'h0000_0327);
        mach.set_pin(IN_ACLR, 1'b1);
        cyc(2);
        chk(o[0], 1'b1);
        mach.set_pin(IN_ACLR, 1'b0);
        cyc(2);
        chk(o[0], 1'b0);
        cyc(SHOT_PULSE_CYC);
        chk(o[2], 1'b0);
    endtask
    task automatic t_cont();
        apb(1, OFS_CLIMIT, 32'h2);
        // Alarmed shots of earlier scenarios are still counted until this clear
        pulse_pin(IN_CCLR);
        mach.shot(1'b1, 2'h1);
        mach.shot(1'b0, 2'h1);
        mach.shot(1'b1, 2'h1);
        cyc(3);
        chk(o[4], 1'b0);
        mach.shot(1'b1, 2'h1);
        cyc(3);
        chk(o[4], 1'b1);
        pulse_pin(IN_CCLR);
        chk(o[4], 1'b0);
    endtask
    task automatic t_prod();
        apb(1, OFS_TARGET, 32'h2);
        apb(1, OFS_GOOD, 32'h0);
        mach.shot(1'b0, 2'h1);
        cyc(3);
        chk(o[3:1], 3'b011);
        mach.shot(1'b0, 2'h1);
        cyc(3);
        chk(o[3], 1'b1);
    endtask
    task automatic t_outs();
        chk(o[5], 1'b1);
        apb(1, OFS_OUTCFG, 32'h0000_0520);
        chk(o[5], 1'b0);
        apb(1, OFS_CTRL, 32'h0000_0304);
        chk(o[5], 1'b1);
        apb(1, OFS_OUTCFG, 32'h0303_0500);
        mach.chans(8'h01, 8'h01);
        cyc(2);
        chk(o[7:6], 2'b00);
        apb(1, OFS_OUTCFG, 32'h0303_3500);
        chk(o[7:6], 2'b11);
        mach.chans(8'h04, 8'h04);
        cyc(2);
        chk(o[7:6], 2'b00);
        apb(1, OFS_OUTCFG, 32'h0303_0500);
        mach.chans(8'h03, 8'h03);
        cyc(2);
        chk(o[7:6], 2'b11);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        cyc(4);
        t_regs();
        t_start();
        t_ctrl();
        t_alarm();
        t_cont();
        t_prod();
        t_outs();
        test_done();
    end
    initial begin
        #2000000;
        n_errors++;
        test_done();
    end
endmodule
`default_nettype wire
